// file: src/panel_serial_config_port.sv
// Panel configuration port: three-wire and two-wire links, frame-sync bank
`timescale 1ns/100ps
module panel_serial_config_port
  import panel_cfg_pkg::*;
(
  // System
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic                     global_reset_input_n,
  input  wire logic                     frame_sync,
  // Three-wire link
  input  wire logic                     spi_sclk,
  input  wire logic                     spi_cs_n,
  input  wire logic                     spi_sda_in,
  output logic                          spi_sda_out,
  output logic                          spi_sda_oe,
  // Two-wire link
  input  wire logic                     i2c_scl_in,
  input  wire logic                     i2c_sda_in,
  output logic                          i2c_sda_out,
  output logic                          i2c_sda_oe,
  // Applied configuration
  output logic [panel_cfg_pkg::BANK_W-1:0] panel_cfg,
  output logic                          power_save
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [PINS-1:0]       s1, s2, s3, filt, filt_q;
  logic [PINS-1:0]       next_filt;
  logic [FRAME_BITS-1:0] frame_word;
  logic [CNT_W-1:0]      frame_count;
  logic                  frame_tag, seen_tag, next_seen;
  logic                  cs_rise, apply, gres;
  logic                  spi_wr, i2c_wr;
  logic [IDX_W-1:0]      spi_idx, i2c_idx;
  logic [DATA_W-1:0]     spi_data, i2c_data;
  logic [BANK_W-1:0]     active, shadow, next_active, next_shadow;
  logic [REG_COUNT-1:0]  pending, next_pending;
  logic                  scl_rise, scl_fall, start_c, stop_c;
  i2c_state_t            ist, next_ist;
  logic [3:0]            bcnt, next_bcnt;
  logic [DATA_W-1:0]     ishift, next_ishift;
  logic [ADDR_W-1:0]     iptr, next_iptr;
  logic                  irw, next_irw, iphase, next_iphase;
  logic                  next_sda_oe;
  logic [DATA_W-1:0]     tx_byte;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Only the second and third stages are looked at
  always_comb begin
    next_filt = (s2 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1     <= PIN_IDLE;
      s2     <= PIN_IDLE;
      s3     <= PIN_IDLE;
      filt   <= PIN_IDLE;
      filt_q <= PIN_IDLE;
    end else begin
      s1     <= {global_reset_input_n, frame_sync, i2c_sda_in,
                 i2c_scl_in, spi_cs_n};
      s2     <= s1;
      s3     <= s2;
      filt   <= next_filt;
      filt_q <= filt;
    end
  end

  // ****************************************
  // Three-wire receiver and frame hand-over
  // ****************************************
  spi_frame_rx u_rx (
    .spi_sclk    (spi_sclk),
    .link_rst_n  (rst_n),
    .spi_cs_n    (spi_cs_n),
    .spi_sda_in  (spi_sda_in),
    .spi_sda_out (spi_sda_out),
    .spi_sda_oe  (spi_sda_oe),
    .rd_bank     (active),
    .frame_word  (frame_word),
    .frame_count (frame_count),
    .frame_tag   (frame_tag)
  );

  // Word is quiet once select is high, so it is read on the synced rise
  always_comb begin
    cs_rise   = filt[P_CS] & ~filt_q[P_CS];
    spi_idx   = frame_word[ADDR_LO +: IDX_W];
    spi_data  = frame_word[DATA_W-1:0];
    spi_wr    = cs_rise && (frame_tag != seen_tag) &&
                (frame_count == CNT_FULL) &&
                !frame_word[RW_POS] &&
                addr_hit(frame_word[ADDR_HI:ADDR_LO]);
    next_seen = cs_rise ? frame_tag : seen_tag;
    apply     = filt[P_FS] & ~filt_q[P_FS];
    gres      = ~filt[P_GRB];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) seen_tag <= 1'b0;
    else        seen_tag <= next_seen;
  end

  // ****************************************
  // Shadow and applied registers
  // ****************************************
  always_comb begin
    next_active  = active;
    next_shadow  = shadow;
    next_pending = pending;
    if (apply) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        if (pending[i]) begin
          next_active[i*DATA_W +: DATA_W] = shadow[i*DATA_W +: DATA_W];
        end
      end
      next_pending = '0;
    end
    // A write in the sync cycle stays pending for the next sync
    if (i2c_wr) begin
      next_shadow[i2c_idx*DATA_W +: DATA_W] = i2c_data;
      next_pending[i2c_idx] = 1'b1;
    end
    if (spi_wr) begin
      next_shadow[spi_idx*DATA_W +: DATA_W] = spi_data;
      next_pending[spi_idx] = 1'b1;
    end
    if (gres) begin
      next_active  = {REG_COUNT{REG_RESET}};
      next_shadow  = {REG_COUNT{REG_RESET}};
      next_pending = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      active  <= {REG_COUNT{REG_RESET}};
      shadow  <= {REG_COUNT{REG_RESET}};
      pending <= '0;
    end else begin
      active  <= next_active;
      shadow  <= next_shadow;
      pending <= next_pending;
    end
  end

  assign panel_cfg  = active;
  // Power save is only an output; both links keep running
  assign power_save = active[PWR_REG*DATA_W + PWR_BIT];

  // ****************************************
  // Two-wire slave
  // ****************************************
  always_comb begin
    scl_rise = filt[P_SCL] & ~filt_q[P_SCL];
    scl_fall = ~filt[P_SCL] & filt_q[P_SCL];
    start_c  = filt[P_SCL] & filt_q[P_SCL] & filt_q[P_SDA] & ~filt[P_SDA];
    stop_c   = filt[P_SCL] & filt_q[P_SCL] & ~filt_q[P_SDA] & filt[P_SDA];
    tx_byte  = reg_pick(active, iptr);
    i2c_idx  = iptr[IDX_W-1:0];
    i2c_data = ishift;
    i2c_wr   = 1'b0;
    next_ist    = ist;
    next_bcnt   = bcnt;
    next_ishift = ishift;
    next_iptr   = iptr;
    next_irw    = irw;
    next_iphase = iphase;
    next_sda_oe = i2c_sda_oe;
    if (start_c) begin
      next_ist    = I_ADDR;
      next_bcnt   = BIT_ZERO;
      next_iphase = 1'b0;
      next_sda_oe = 1'b0;
    end else if (stop_c) begin
      next_ist    = I_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      unique case (ist)
        I_IDLE: begin
          next_sda_oe = 1'b0;
        end
        I_ADDR, I_RX: begin
          if (scl_rise && bcnt != BIT_FULL) begin
            next_ishift = {ishift[DATA_W-2:0], filt[P_SDA]};
            next_bcnt   = bcnt + BIT_STEP;
          end else if (scl_fall && bcnt == BIT_FULL) begin
            next_bcnt   = BIT_ZERO;
            next_ist    = I_ACK;
            next_sda_oe = 1'b1;
            if (ist == I_ADDR) begin
              next_irw = ishift[0];
              if (ishift[DATA_W-1:1] != I2C_ADDR) begin
                next_ist    = I_IDLE;
                next_sda_oe = 1'b0;
              end
            end else if (!iphase) begin
              next_iptr   = ishift[ADDR_W-1:0];
              next_iphase = 1'b1;
            end else begin
              i2c_wr      = addr_hit(iptr);
              next_iptr   = iptr + PTR_STEP;
              next_iphase = 1'b0;
            end
          end
        end
        I_ACK: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_ist    = I_RX;
            if (irw) begin
              next_ishift = tx_byte;
              next_sda_oe = ~tx_byte[DATA_W-1];
              next_ist    = I_TX;
            end
          end
        end
        I_TX: begin
          if (scl_fall) begin
            next_bcnt = bcnt + BIT_STEP;
            if (bcnt == BIT_LAST) begin
              next_sda_oe = 1'b0;
              next_ist    = I_TXACK;
              next_iptr   = iptr + PTR_STEP;
              next_bcnt   = BIT_ZERO;
            end else begin
              next_ishift = {ishift[DATA_W-2:0], 1'b0};
              next_sda_oe = ~ishift[DATA_W-2];
            end
          end
        end
        I_TXACK: begin
          if (scl_rise) begin
            next_ist = filt[P_SDA] ? I_IDLE : I_TXLD;
          end
        end
        I_TXLD: begin
          if (scl_fall) begin
            next_ishift = tx_byte;
            next_sda_oe = ~tx_byte[DATA_W-1];
            next_ist    = I_TX;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ist        <= I_IDLE;
      bcnt       <= BIT_ZERO;
      ishift     <= '0;
      iptr       <= '0;
      irw        <= 1'b0;
      iphase     <= 1'b0;
      i2c_sda_oe <= 1'b0;
    end else begin
      ist        <= next_ist;
      bcnt       <= next_bcnt;
      ishift     <= next_ishift;
      iptr       <= next_iptr;
      irw        <= next_irw;
      iphase     <= next_iphase;
      i2c_sda_oe <= next_sda_oe;
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge clk_sys) begin
    i2c_sda_out <= 1'b0;
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_start;
    filt[P_SCL] && filt_q[P_SCL] && filt_q[P_SDA] && !filt[P_SDA];
  endsequence
  sequence s_stop;
    filt[P_SCL] && filt_q[P_SCL] && !filt_q[P_SDA] && filt[P_SDA];
  endsequence
  sequence s_nack;
    ist == I_TXACK && scl_rise && filt[P_SDA];
  endsequence

  property p_short_drop;
    cs_rise && frame_count < CNT_FULL && !i2c_wr && !apply && !gres
      |=> pending == $past(pending);
  endproperty
  a_short_drop: assert property (p_short_drop)
    else $error("short frame changed pending writes");

  property p_read_no_write;
    cs_rise && frame_word[RW_POS] |-> !spi_wr;
  endproperty
  a_read_no_write: assert property (p_read_no_write)
    else $error("read frame caused a write");

  property p_hold_until_sync;
    !apply && !gres |=> active == $past(active);
  endproperty
  a_hold_until_sync: assert property (p_hold_until_sync)
    else $error("applied bank changed without frame sync");

  property p_latest_wins;
    spi_wr && !gres
      |=> shadow[$past(spi_idx)*DATA_W +: DATA_W] == $past(spi_data);
  endproperty
  a_latest_wins: assert property (p_latest_wins)
    else $error("latest write not held in shadow");

  property p_sync_moves;
    apply && !gres && !spi_wr && !i2c_wr |=> pending == '0;
  endproperty
  a_sync_moves: assert property (p_sync_moves)
    else $error("pending writes left after frame sync");

  property p_start_seen;
    s_start |=> ist == I_ADDR && bcnt == BIT_ZERO && !i2c_sda_oe;
  endproperty
  a_start_seen: assert property (p_start_seen)
    else $error("start condition missed");

  property p_stop_seen;
    s_stop |=> ist == I_IDLE ##1 !i2c_sda_oe;
  endproperty
  a_stop_seen: assert property (p_stop_seen)
    else $error("stop condition missed");

  property p_ack_low;
    ist == I_ACK |-> i2c_sda_oe && !i2c_sda_out;
  endproperty
  a_ack_low: assert property (p_ack_low)
    else $error("acknowledge not driven low");

  property p_nack_release;
    (s_nack and (!start_c && !stop_c))
      |=> ist == I_IDLE [*2] ##0 !i2c_sda_oe;
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("read continued after missing acknowledge");

  property p_addr_match;
    ist == I_ADDR && scl_fall && bcnt == BIT_FULL && !start_c && !stop_c &&
      ishift[DATA_W-1:1] != I2C_ADDR |=> ist == I_IDLE;
  endproperty
  a_addr_match: assert property (p_addr_match)
    else $error("foreign address was answered");

endmodule

// file: shared/panel_cfg_pkg.sv
// Constants, types and shared decode for the panel serial configuration port
package panel_cfg_pkg;

  // ****************************************
  // Word and register bank layout
  // ****************************************
  localparam int DATA_W     = 8;
  localparam int ADDR_W     = 7;
  localparam int IDX_W      = 4;
  localparam int REG_COUNT  = 16;
  localparam int BANK_W     = REG_COUNT * DATA_W;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W      = 5;
  localparam int RW_POS     = 15;
  localparam int ADDR_HI    = 14;
  localparam int ADDR_LO    = 8;
  localparam int HDR_RW     = 7;
  localparam int PWR_BIT    = 0;
  localparam logic [IDX_W-1:0]  PWR_REG   = 4'h0;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] I2C_ADDR  = 7'h3c;

  // ****************************************
  // Counter constants
  // ****************************************
  localparam logic [CNT_W-1:0] CNT_FULL  = 5'h10;
  localparam logic [CNT_W-1:0] CNT_HDR   = 5'h08;
  localparam logic [CNT_W-1:0] CNT_FIRST = 5'h01;
  localparam logic [CNT_W-1:0] CNT_STEP  = 5'h01;
  localparam logic [3:0]       BIT_LAST  = 4'h7;
  localparam logic [3:0]       BIT_FULL  = 4'h8;
  localparam logic [3:0]       BIT_ZERO  = 4'h0;
  localparam logic [3:0]       BIT_STEP  = 4'h1;
  localparam logic [ADDR_W-1:0] PTR_STEP = 7'h01;

  // ****************************************
  // Pin synchroniser lanes
  // ****************************************
  localparam int PINS  = 5;
  localparam int P_CS  = 0;
  localparam int P_SCL = 1;
  localparam int P_SDA = 2;
  localparam int P_FS  = 3;
  localparam int P_GRB = 4;
  localparam logic [PINS-1:0] PIN_IDLE = 5'h17;

  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_ACK, I_RX, I_TX, I_TXACK, I_TXLD
  } i2c_state_t;

  // Registers above the bank read as zero and ignore writes
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a[ADDR_W-1:IDX_W] == '0);
  endfunction

  function automatic logic [DATA_W-1:0] reg_pick(
    input logic [BANK_W-1:0] bank,
    input logic [ADDR_W-1:0] a
  );
    reg_pick = addr_hit(a) ? bank[a[IDX_W-1:0]*DATA_W +: DATA_W] : REG_RESET;
  endfunction

endpackage

// file: src/spi_frame_rx.sv
// Three-wire frame receiver running on the serial clock
`timescale 1ns/100ps
module spi_frame_rx
  import panel_cfg_pkg::*;
(
  // Link
  input  wire logic                         spi_sclk,
  input  wire logic                         link_rst_n,
  input  wire logic                         spi_cs_n,
  input  wire logic                         spi_sda_in,
  output logic                              spi_sda_out,
  output logic                              spi_sda_oe,
  // Towards system domain
  input  wire logic [panel_cfg_pkg::BANK_W-1:0] rd_bank,
  output logic [FRAME_BITS-1:0]             frame_word,
  output logic [CNT_W-1:0]                  frame_count,
  output logic                              frame_tag
);

  // ****************************************
  // Shift side
  // ****************************************
  logic              link_clr;
  logic              open_f;
  logic [DATA_W-1:0] hdr;
  logic [FRAME_BITS-1:0] next_word;
  logic [CNT_W-1:0]  next_count;
  logic              next_tag;
  logic [DATA_W-1:0] next_hdr;
  logic [DATA_W-1:0] rd_byte;
  logic              next_oe;
  logic              next_out;

  // Frame ends with its own select, no edge after it is needed
  assign link_clr = spi_cs_n | ~link_rst_n;

  always_ff @(posedge spi_sclk or posedge link_clr) begin
    if (link_clr) open_f <= 1'b0;
    else          open_f <= 1'b1;
  end

  always_comb begin
    next_word  = {frame_word[FRAME_BITS-2:0], spi_sda_in};
    next_count = CNT_FIRST;
    next_tag   = ~frame_tag;
    if (open_f) begin
      next_tag   = frame_tag;
      next_count = (frame_count == CNT_FULL) ? frame_count
                                             : frame_count + CNT_STEP;
    end
    next_hdr = (next_count == CNT_HDR) ? next_word[DATA_W-1:0] : hdr;
  end

  // Serial clock drives this logic directly
  always_ff @(posedge spi_sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      frame_word  <= '0;
      frame_count <= '0;
      frame_tag   <= 1'b0;
      hdr         <= '0;
    end else begin
      frame_word  <= next_word;
      frame_count <= next_count;
      frame_tag   <= next_tag;
      hdr         <= next_hdr;
    end
  end

  // ****************************************
  // Read data, driven on falling edges
  // ****************************************
  // Bank changes only at frame sync or global reset; a read spanning one may tear
  always_comb begin
    rd_byte  = reg_pick(rd_bank, hdr[ADDR_W-1:0]);
    next_oe  = open_f && hdr[HDR_RW] && (frame_count >= CNT_HDR) &&
               (frame_count < CNT_FULL);
    next_out = rd_byte[3'(CNT_FULL - CNT_STEP - frame_count)];
  end

  always_ff @(negedge spi_sclk or posedge link_clr) begin
    if (link_clr) begin
      spi_sda_oe  <= 1'b0;
      spi_sda_out <= 1'b0;
    end else begin
      spi_sda_oe  <= next_oe;
      spi_sda_out <= next_out;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_count_bound;
    @(posedge spi_sclk) disable iff (link_clr)
      frame_count <= CNT_FULL;
  endproperty
  a_count_bound: assert property (p_count_bound)
    else $error("bit count passed a full frame");

  property p_bit_taken;
    @(posedge spi_sclk) disable iff (link_clr)
      open_f |=> frame_word[0] == $past(spi_sda_in);
  endproperty
  a_bit_taken: assert property (p_bit_taken)
    else $error("serial bit not shifted in");

endmodule

// file: tb/host_link_model.sv
// Host controller model for the three-wire and two-wire links
`timescale 1ns/100ps
module host_link_model (
  // Three-wire link
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_sda_in,
  input  wire logic spi_sda_out,
  input  wire logic spi_sda_oe,
  // Two-wire link
  output logic      i2c_scl_in,
  output logic      i2c_sda_in,
  input  wire logic i2c_sda_out,
  input  wire logic i2c_sda_oe
);
  localparam realtime HALF = 7.5;
  localparam int      Q    = 100;
  logic host_sda;
  logic drv_sda;

  // ****************************************
  // Wire levels
  // ****************************************
  // Released line toggles so a stale value never passes for data
  assign spi_sda_in = spi_sda_oe ? spi_sda_out : host_sda;
  // Pull-up wins unless someone pulls low
  assign i2c_sda_in = drv_sda & ~(i2c_sda_oe & ~i2c_sda_out);

  initial begin
    spi_sclk   = 1'b0;
    spi_cs_n   = 1'b1;
    host_sda   = 1'b0;
    i2c_scl_in = 1'b1;
    drv_sda    = 1'b1;
  end

  // ****************************************
  // Three-wire frame, low n bits of w, highest first
  // ****************************************
  task automatic spi_xfer(input logic [19:0] w, input int n,
                          output logic [7:0] rd);
    logic rel;
    rd = 8'h00;
    spi_cs_n = 1'b0;
    #(HALF);
    for (int i = n - 1; i >= 0; i--) begin
      rel = w[n-1] && (n - 1 - i) >= 8;
      host_sda = rel ? ~host_sda : w[i];
      #(HALF);
      if (rel) begin
        rd = {rd[6:0], spi_sda_in};
      end
      spi_sclk = 1'b1;
      #(HALF);
      spi_sclk = 1'b0;
    end
    #(HALF);
    spi_cs_n = 1'b1;
    #60;
  endtask

  // ****************************************
  // Two-wire conditions and bytes
  // ****************************************
  task automatic i2c_start();
    drv_sda = 1'b1;
    i2c_scl_in = 1'b1;
    #Q;
    drv_sda = 1'b0;
    #Q;
    i2c_scl_in = 1'b0;
    #Q;
  endtask

  task automatic i2c_stop();
    drv_sda = 1'b0;
    #Q;
    i2c_scl_in = 1'b1;
    #Q;
    drv_sda = 1'b1;
    #Q;
  endtask

  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      drv_sda = b[i];
      #Q;
      i2c_scl_in = 1'b1;
      #(2 * Q);
      i2c_scl_in = 1'b0;
      #Q;
    end
    drv_sda = 1'b1;
    #Q;
    i2c_scl_in = 1'b1;
    #Q;
    ack = ~i2c_sda_in;
    #Q;
    i2c_scl_in = 1'b0;
    #Q;
  endtask

  // Read one byte with the line released, then acknowledge or not
  task automatic i2c_rd(input logic nack, output logic [7:0] b);
    b = 8'h00;
    drv_sda = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #Q;
      i2c_scl_in = 1'b1;
      #Q;
      b[i] = i2c_sda_in;
      #Q;
      i2c_scl_in = 1'b0;
      #Q;
    end
    drv_sda = nack;
    #Q;
    i2c_scl_in = 1'b1;
    #(2 * Q);
    i2c_scl_in = 1'b0;
    #Q;
  endtask
endmodule

// file: tb/tb_panel_serial_config_port.sv
// Self-checking bench for the panel serial configuration port
`timescale 1ns/100ps
module tb_panel_serial_config_port;
  import panel_cfg_pkg::*;
  logic              clk_sys;
  logic              rst_n;
  logic              global_reset_input_n;
  logic              frame_sync;
  logic              spi_sclk;
  logic              spi_cs_n;
  logic              spi_sda_in;
  logic              spi_sda_out;
  logic              spi_sda_oe;
  logic              i2c_scl_in;
  logic              i2c_sda_in;
  logic              i2c_sda_out;
  logic              i2c_sda_oe;
  logic [BANK_W-1:0] panel_cfg;
  logic              power_save;
  logic [BANK_W-1:0] exp_bank;
  int                n_errors;
  int                check_count;

  panel_serial_config_port uut (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .global_reset_input_n(global_reset_input_n), .frame_sync(frame_sync),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sda_in(spi_sda_in),
    .spi_sda_out(spi_sda_out), .spi_sda_oe(spi_sda_oe),
    .i2c_scl_in(i2c_scl_in), .i2c_sda_in(i2c_sda_in),
    .i2c_sda_out(i2c_sda_out), .i2c_sda_oe(i2c_sda_oe),
    .panel_cfg(panel_cfg), .power_save(power_save));

  host_link_model host (
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sda_in(spi_sda_in),
    .spi_sda_out(spi_sda_out), .spi_sda_oe(spi_sda_oe),
    .i2c_scl_in(i2c_scl_in), .i2c_sda_in(i2c_sda_in),
    .i2c_sda_out(i2c_sda_out), .i2c_sda_oe(i2c_sda_oe));

  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic check(input logic [BANK_W-1:0] got,
                       input logic [BANK_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Pulse long enough for the three-flop pin synchroniser
  task automatic sync_pulse();
    @(posedge clk_sys);
    frame_sync <= 1'b1;
    repeat (4) @(posedge clk_sys);
    frame_sync <= 1'b0;
    repeat (12) @(posedge clk_sys);
  endtask

  task automatic spi_wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] rd;
    host.spi_xfer({4'h0, 1'b0, a, d}, 16, rd);
    repeat (8) @(posedge clk_sys);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    exp_bank = '0;
    check(panel_cfg, exp_bank);
    check(power_save, 1'b0);
    check({spi_sda_oe, i2c_sda_oe, i2c_sda_out}, 3'b000);
  endtask

  task automatic t_write_at_sync();
    spi_wr(7'h03, 8'ha5);
    check(panel_cfg, exp_bank);
    sync_pulse();
    exp_bank[3*DATA_W +: DATA_W] = 8'ha5;
    check(panel_cfg, exp_bank);
  endtask

  task automatic t_last_wins();
    spi_wr(7'h05, 8'h11);
    spi_wr(7'h05, 8'h22);
    sync_pulse();
    exp_bank[5*DATA_W +: DATA_W] = 8'h22;
    check(panel_cfg, exp_bank);
  endtask

  task automatic t_short_and_long();
    logic [7:0] rd;
    host.spi_xfer({5'h00, 7'h06, 8'h77}, 15, rd);
    repeat (8) @(posedge clk_sys);
    sync_pulse();
    check(panel_cfg, exp_bank);
    // Leading nibble must be shifted out, not applied
    host.spi_xfer({4'h5, 1'b0, 7'h07, 8'h3c}, 20, rd);
    repeat (8) @(posedge clk_sys);
    sync_pulse();
    exp_bank[7*DATA_W +: DATA_W] = 8'h3c;
    check(panel_cfg, exp_bank);
  endtask

  task automatic t_read();
    logic [7:0] rd;
    host.spi_xfer({4'h0, 1'b1, 7'h03, 8'h00}, 16, rd);
    check(rd, 8'ha5);
    check(spi_sda_oe, 1'b0);
    sync_pulse();
    check(panel_cfg, exp_bank);
  endtask

  task automatic t_power_save();
    spi_wr(7'h00, 8'h01);
    sync_pulse();
    exp_bank[0 +: DATA_W] = 8'h01;
    check(power_save, 1'b1);
    spi_wr(7'h08, 8'h66);
    sync_pulse();
    exp_bank[8*DATA_W +: DATA_W] = 8'h66;
    check(panel_cfg, exp_bank);
  endtask

  task automatic t_two_wire();
    logic ack;
    host.i2c_start();
    host.i2c_byte({I2C_ADDR, 1'b0}, ack);
    check(ack, 1'b1);
    host.i2c_byte(8'h09, ack);
    check(ack, 1'b1);
    host.i2c_byte(8'h5a, ack);
    check(ack, 1'b1);
    host.i2c_stop();
    check(i2c_sda_oe, 1'b0);
    sync_pulse();
    exp_bank[9*DATA_W +: DATA_W] = 8'h5a;
    check(panel_cfg, exp_bank);
    // Other address: silent, no write lands
    host.i2c_start();
    host.i2c_byte(8'h7c, ack);
    check(ack, 1'b0);
    host.i2c_byte(8'h0a, ack);
    host.i2c_byte(8'h99, ack);
    host.i2c_stop();
    sync_pulse();
    check(panel_cfg, exp_bank);
  endtask

  task automatic t_two_wire_read();
    logic       ack;
    logic [7:0] rd;
    host.i2c_start();
    host.i2c_byte({I2C_ADDR, 1'b0}, ack);
    host.i2c_byte(8'h09, ack);
    // Repeated start turns the bus round, pointer kept
    host.i2c_start();
    host.i2c_byte({I2C_ADDR, 1'b1}, ack);
    check(ack, 1'b1);
    host.i2c_rd(1'b1, rd);
    check(rd, 8'h5a);
    check(i2c_sda_oe, 1'b0);
    host.i2c_stop();
    sync_pulse();
    check(panel_cfg, exp_bank);
  endtask

  task automatic t_global_reset();
    @(posedge clk_sys);
    global_reset_input_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    global_reset_input_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    exp_bank = '0;
    check(panel_cfg, exp_bank);
    spi_wr(7'h0f, 8'hc3);
    sync_pulse();
    exp_bank[15*DATA_W +: DATA_W] = 8'hc3;
    check(panel_cfg, exp_bank);
  endtask

  // ****************************************
  // Clock, reset, sequence, watchdog
  // ****************************************
  initial begin
    clk_sys = 1'b0;
  end

  always begin
    #2 clk_sys = ~clk_sys;
  end

  initial begin
    n_errors = 0;
    check_count = 0;
    rst_n = 1'b0;
    global_reset_input_n = 1'b1;
    frame_sync = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    // Host start-up wait, cut far short of real time
    repeat (6) @(posedge clk_sys);
    t_write_at_sync();
    t_last_wins();
    t_short_and_long();
    t_read();
    t_power_save();
    t_two_wire();
    t_two_wire_read();
    t_global_reset();
    print_verdict();
  end

  initial begin
    repeat (90000) @(posedge clk_sys);
    n_errors++;
    print_verdict();
  end
endmodule
